// file: src/adg_regs.sv
// Operation
// - Start delay write restarts the channel.
// - Start delay is field plus half oversampling.
// - Gain codes 0 to 5 give 1 to 32.
// - Gain codes 6 and 7 give gain 1.
// - Read auto-increment loops map, types or groups.
// - Read mode zero keeps the same address.
// - Write loop bit loops writable map, else static.
// - Idle bit drives ready pin high, else released.
// - Wide checksum adds sixteen zero bits.
// - Format code selects 32, 24 or 16-bit words.
// - Link checksum enable appends CRC to sequences.
// - Checksum failure with alert pulls ready low.
// - Unlock key 0xA5 clears the alert.
// - Alert disabled still keeps checksum readable.
// - Bitstream pin driven only while enabled.
// - Ready flag reads zero when data ready.
// - Status read sets ready flag to one.
// - Channel read leaves ready flag alone.
// - Channel word latched when its read begins.
//
// The Avalon-MM interface to the registers was left to the implementer.
`include "adg_params.svh"

module adg_regs #(
    parameter int OSR_W = 13
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire adg_pkg::adg_amm_req_t amm_req,
    output adg_pkg::adg_amm_rsp_t amm_rsp,
    input wire logic sample_valid,
    input wire logic [23:0] sample_data,
    input wire logic [OSR_W-1:0] oversample_ratio,
    input wire logic checksum_fail,
    input wire logic [15:0] config_checksum_value,
    input wire logic modulator_bit,
    input wire adg_pkg::adg_seq_req_t seq_req,
    output logic [5:0] link_addr,
    output adg_pkg::adg_link_cfg_t link_cfg,
    output logic chan_restart_ff,
    output logic conv_start_ff,
    output logic [5:0] amp_gain_factor_ff,
    output logic [31:0] sample_word_ff,
    output logic sample_ready_pin_n_o_ff,
    output logic sample_ready_pin_n_oe_ff,
    output logic bitstream_pin_o_ff,
    output logic bitstream_pin_oe
);
    import adg_pkg::*;

    localparam int CNT_W = OSR_W;

    logic busy;
    logic ack_ff;
    logic wr_take;
    logic rd_done;
    logic rd_start;
    logic [5:0] idx;
    logic [31:0] rdata_ff;
    logic [31:0] rd_word;
    logic [11:0] delay_ff;
    logic [2:0] gain_ff;
    logic [23:0] stat_ff;
    logic flag_ff;
    logic alert_ff;
    logic [7:0] lock_key_ff;
    logic [23:0] sample_ff;
    logic [31:0] mrg_delay;
    logic [31:0] mrg_gain;
    logic [31:0] mrg_stat;
    logic [31:0] mrg_lock;
    logic [CNT_W-1:0] dly_cnt_ff;
    logic [CNT_W-1:0] dly_total;
    adg_dly_state_t dly_state_ff;
    logic unlock_hit;

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] be_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        for (int i = 0; i < 4; i++) begin
            be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Gain factor for an amplifier gain code.
    function automatic logic [5:0] gain_of(input logic [2:0] code);
        case (code)
            3'h0: gain_of = 6'h01;
            3'h1: gain_of = 6'h02;
            3'h2: gain_of = 6'h04;
            3'h3: gain_of = 6'h08;
            3'h4: gain_of = 6'h10;
            3'h5: gain_of = 6'h20;
            default: gain_of = 6'h01;
        endcase
    endfunction

    // Shapes a 24-bit sample into the selected output word.
    function automatic logic [31:0] fmt_word(
        input logic [1:0] fmt,
        input logic [23:0] d
    );
        logic [15:0] hi;
        hi = d[23:8];
        case (fmt)
            `ADG_FMT_32S: fmt_word = {{8{d[23]}}, d};
            `ADG_FMT_32Z: fmt_word = {d, 8'h00};
            `ADG_FMT_24: fmt_word = {8'h00, d};
            default: begin
                // Rounding saturates at the top positive code.
                if (d[7] && hi != 16'h7FFF) begin
                    fmt_word = {16'h0000, hi + 16'h0001};
                end else begin
                    fmt_word = {16'h0000, hi};
                end
            end
        endcase
    endfunction

    // Bus handshake: one wait cycle, then the access completes.
    assign busy = amm_req.read | amm_req.write;
    assign idx = amm_req.address[7:2];
    assign wr_take = amm_req.write & ack_ff;
    assign rd_done = amm_req.read & ack_ff;
    assign rd_start = amm_req.read & ~ack_ff;
    assign amm_rsp.waitrequest = busy & ~ack_ff;
    assign amm_rsp.readdata = rdata_ff;

    // Acknowledge flag for the wait cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= busy & ~ack_ff;
        end
    end

    // Read word selection; unmapped addresses read zero.
    always_comb begin
        rd_word = 32'h00000000;
        case (idx)
            `ADG_IDX_CHAN: rd_word = {8'h00, sample_ff};
            `ADG_IDX_DELAY: rd_word = {20'h00000, delay_ff};
            `ADG_IDX_GAIN: rd_word = {29'h00000000, gain_ff};
            `ADG_IDX_STAT: begin
                rd_word = {8'h00, stat_ff & `ADG_STAT_WMASK};
                rd_word[`ADG_ST_FLAG] = flag_ff;
            end
            `ADG_IDX_LOCK: begin
                rd_word = {8'h00, lock_key_ff, config_checksum_value};
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    // Read data are captured as the read begins and then held.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_start) begin
            rdata_ff <= rd_word;
        end
    end

    // Byte-lane merges for each writable register.
    always_comb begin
        mrg_delay = be_merge({20'h00000, delay_ff},
            amm_req.writedata, amm_req.byteenable);
        mrg_gain = be_merge({29'h00000000, gain_ff},
            amm_req.writedata, amm_req.byteenable);
        mrg_stat = be_merge({8'h00, stat_ff},
            amm_req.writedata, amm_req.byteenable);
        mrg_lock = be_merge({8'h00, lock_key_ff, 16'h0000},
            amm_req.writedata, amm_req.byteenable);
    end

    // Start delay field; only its twelve bits are stored.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            delay_ff <= `ADG_DELAY_RST;
        end else if (wr_take && idx == `ADG_IDX_DELAY) begin
            delay_ff <= mrg_delay[11:0];
        end
    end

    // Amplifier gain code.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gain_ff <= `ADG_GAIN_RST;
        end else if (wr_take && idx == `ADG_IDX_GAIN) begin
            gain_ff <= mrg_gain[2:0];
        end
    end

    // Status and link settings; reserved and flag bits are masked off.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_ff <= `ADG_STAT_RST & `ADG_STAT_WMASK;
        end else if (wr_take && idx == `ADG_IDX_STAT) begin
            stat_ff <= mrg_stat[23:0] & `ADG_STAT_WMASK;
        end
    end

    // Ready flag: a new sample wins over a status read in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_ff <= 1'b1;
        end else if (sample_valid) begin
            flag_ff <= 1'b0;
        end else if (rd_done && idx == `ADG_IDX_STAT) begin
            flag_ff <= 1'b1;
        end
    end

    // Latest conversion result; a channel read does not touch the flag.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_ff <= 24'h000000;
        end else if (sample_valid) begin
            sample_ff <= sample_data;
        end
    end

    // Lock key field, written by the host and read back.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lock_key_ff <= `ADG_LOCK_RST;
        end else if (wr_take && idx == `ADG_IDX_LOCK) begin
            lock_key_ff <= mrg_lock[23:16];
        end
    end

    assign unlock_hit = wr_take && idx == `ADG_IDX_LOCK
        && amm_req.byteenable[2]
        && amm_req.writedata[23:16] == `ADG_UNLOCK_KEY;

    // Checksum alert: a new failure wins over the unlock clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alert_ff <= 1'b0;
        end else if (checksum_fail && stat_ff[`ADG_ST_ALERT]) begin
            alert_ff <= 1'b1;
        end else if (unlock_hit) begin
            alert_ff <= 1'b0;
        end
    end

    // Ready pin: alert holds it low, ready data drive it low.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_ready_pin_n_o_ff <= 1'b1;
            sample_ready_pin_n_oe_ff <= 1'b0;
        end else if (alert_ff) begin
            sample_ready_pin_n_o_ff <= 1'b0;
            sample_ready_pin_n_oe_ff <= 1'b1;
        end else if (!flag_ff) begin
            sample_ready_pin_n_o_ff <= 1'b0;
            sample_ready_pin_n_oe_ff <= 1'b1;
        end else begin
            sample_ready_pin_n_o_ff <= 1'b1;
            sample_ready_pin_n_oe_ff <= stat_ff[`ADG_ST_IDLE];
        end
    end

    // Bitstream pin follows the modulator only while enabled.
    assign bitstream_pin_oe = stat_ff[`ADG_ST_MDAT];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bitstream_pin_o_ff <= 1'b0;
        end else begin
            bitstream_pin_o_ff <= stat_ff[`ADG_ST_MDAT] & modulator_bit;
        end
    end

    // Gain factor and formatted sample word for the datapath.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            amp_gain_factor_ff <= 6'h01;
        end else begin
            amp_gain_factor_ff <= gain_of(gain_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_word_ff <= 32'h00000000;
        end else begin
            sample_word_ff <= fmt_word(stat_ff[`ADG_ST_FMT_HI:`ADG_ST_FMT_LO],
                sample_ff);
        end
    end

    // Any write to the start delay register restarts the channel.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chan_restart_ff <= 1'b0;
        end else begin
            chan_restart_ff <= wr_take && idx == `ADG_IDX_DELAY;
        end
    end

    // Delay in modulator clocks: field plus half the oversampling ratio.
    assign dly_total = CNT_W'(delay_ff) + CNT_W'(oversample_ratio >> 1);

    // Start delay counter, re-armed after reset and on every restart.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dly_state_ff <= DLY_ARM;
            dly_cnt_ff <= '0;
            conv_start_ff <= 1'b0;
        end else if (chan_restart_ff) begin
            dly_state_ff <= DLY_COUNT;
            dly_cnt_ff <= dly_total;
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= 1'b0;
            case (dly_state_ff)
                DLY_ARM: begin
                    dly_state_ff <= DLY_COUNT;
                    dly_cnt_ff <= dly_total;
                end
                DLY_COUNT: begin
                    if (dly_cnt_ff <= CNT_W'(1)) begin
                        dly_state_ff <= DLY_RUN;
                        conv_start_ff <= 1'b1;
                    end else begin
                        dly_cnt_ff <= dly_cnt_ff - CNT_W'(1);
                    end
                end
                DLY_RUN: dly_state_ff <= DLY_RUN;
                default: dly_state_ff <= DLY_ARM;
            endcase
        end
    end

    // Settings handed to the serial link.
    always_comb begin
        link_cfg.read_mode = stat_ff[`ADG_ST_RD_HI:`ADG_ST_RD_LO];
        link_cfg.write_loop = stat_ff[`ADG_ST_WR];
        link_cfg.crc_wide = stat_ff[`ADG_ST_CRCW];
        link_cfg.data_fmt = stat_ff[`ADG_ST_FMT_HI:`ADG_ST_FMT_LO];
        link_cfg.checksum_en = stat_ff[`ADG_ST_CRCEN];
        if (!stat_ff[`ADG_ST_CRCEN]) begin
            link_cfg.crc_bits = `ADG_BITS_0;
        end else if (stat_ff[`ADG_ST_CRCW]) begin
            link_cfg.crc_bits = `ADG_BITS_32;
        end else begin
            link_cfg.crc_bits = `ADG_BITS_16;
        end
        case (stat_ff[`ADG_ST_FMT_HI:`ADG_ST_FMT_LO])
            `ADG_FMT_32S: link_cfg.word_bits = `ADG_BITS_32;
            `ADG_FMT_32Z: link_cfg.word_bits = `ADG_BITS_32;
            `ADG_FMT_24: link_cfg.word_bits = `ADG_BITS_24;
            default: link_cfg.word_bits = `ADG_BITS_16;
        endcase
    end

    // Serial address counter.
    adg_addr_seq u_addr_seq (
        .clk(clk),
        .rst_b(rst_b),
        .seq_req(seq_req),
        .read_mode(stat_ff[`ADG_ST_RD_HI:`ADG_ST_RD_LO]),
        .write_loop(stat_ff[`ADG_ST_WR]),
        .addr_ff(link_addr)
    );

endmodule // adg_regs

// file: src/adg_params.svh
`ifndef ADG_PARAMS_SVH
`define ADG_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define ADG_IDX_CHAN 6'h00
`define ADG_IDX_DELAY 6'h0A
`define ADG_IDX_GAIN 6'h0B
`define ADG_IDX_STAT 6'h0C
`define ADG_IDX_LOCK 6'h1F

// Address sequencer loop bounds and group ends.
`define ADG_SEQ_FIRST_CFG 6'h08
`define ADG_SEQ_LAST_CFG 6'h10
`define ADG_SEQ_GRP_B_END 6'h0C
`define ADG_SEQ_GRP_C_END 6'h0E

// Status and link register field positions.
`define ADG_ST_RD_HI 23
`define ADG_ST_RD_LO 22
`define ADG_ST_WR 21
`define ADG_ST_IDLE 20
`define ADG_ST_CRCW 18
`define ADG_ST_FMT_HI 17
`define ADG_ST_FMT_LO 16
`define ADG_ST_CRCEN 15
`define ADG_ST_ALERT 14
`define ADG_ST_MDAT 11
`define ADG_ST_FLAG 0

// Reset values, writable masks and unlock key.
`define ADG_STAT_RST 24'hA10001
`define ADG_STAT_WMASK 24'hF7C800
`define ADG_DELAY_RST 12'h000
`define ADG_GAIN_RST 3'h0
`define ADG_LOCK_RST 8'h00
`define ADG_UNLOCK_KEY 8'hA5

// Field codes.
`define ADG_RD_MAP 2'h3
`define ADG_RD_TYPE 2'h2
`define ADG_RD_GROUP 2'h1
`define ADG_RD_STATIC 2'h0
`define ADG_FMT_32S 2'h3
`define ADG_FMT_32Z 2'h2
`define ADG_FMT_24 2'h1
`define ADG_FMT_16 2'h0

// Bit counts reported to the serial link.
`define ADG_BITS_0 6'h00
`define ADG_BITS_16 6'h10
`define ADG_BITS_24 6'h18
`define ADG_BITS_32 6'h20

`endif

// file: src/adg_pkg.sv
package adg_pkg;

    // Avalon-MM request from the bus master.
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } adg_amm_req_t;

    // Avalon-MM answer to the bus master.
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } adg_amm_rsp_t;

    // Serial link settings taken from the status and link register.
    typedef struct packed {
        logic [1:0] read_mode;
        logic write_loop;
        logic crc_wide;
        logic [1:0] data_fmt;
        logic checksum_en;
        logic [5:0] crc_bits;
        logic [5:0] word_bits;
    } adg_link_cfg_t;

    // Address counter commands from the serial link.
    typedef struct packed {
        logic start;
        logic [5:0] addr;
        logic step;
        logic is_write;
    } adg_seq_req_t;

    // Conversion start delay sequencing.
    typedef enum logic [1:0] {
        DLY_ARM,
        DLY_COUNT,
        DLY_RUN
    } adg_dly_state_t;

endpackage

// file: src/adg_addr_seq.sv
`include "adg_params.svh"

module adg_addr_seq (
    input wire logic clk,
    input wire logic rst_b,
    input wire adg_pkg::adg_seq_req_t seq_req,
    input wire logic [1:0] read_mode,
    input wire logic write_loop,
    output logic [5:0] addr_ff
);
    import adg_pkg::*;

    logic [5:0] nxt_addr;

    // Next implemented address over the whole map, wrapping to zero.
    function automatic logic [5:0] map_next(input logic [5:0] a);
        if (a == `ADG_IDX_CHAN) begin
            map_next = `ADG_SEQ_FIRST_CFG;
        end else if (a >= `ADG_SEQ_LAST_CFG) begin
            map_next = (a == `ADG_IDX_LOCK) ? `ADG_IDX_CHAN : `ADG_IDX_LOCK;
        end else begin
            map_next = a + 6'h01;
        end
    endfunction

    // Next address inside the configuration type, which is also writable.
    function automatic logic [5:0] cfg_next(input logic [5:0] a);
        if (a == `ADG_IDX_LOCK || a < `ADG_SEQ_FIRST_CFG) begin
            cfg_next = `ADG_SEQ_FIRST_CFG;
        end else begin
            cfg_next = map_next(a);
        end
    endfunction

    // First and last address of the group holding an address.
    function automatic logic [5:0] grp_first(input logic [5:0] a);
        if (a < `ADG_SEQ_FIRST_CFG || a > `ADG_SEQ_LAST_CFG) begin
            grp_first = a;
        end else if (a <= `ADG_SEQ_GRP_B_END) begin
            grp_first = `ADG_SEQ_FIRST_CFG;
        end else if (a <= `ADG_SEQ_GRP_C_END) begin
            grp_first = `ADG_SEQ_GRP_B_END + 6'h01;
        end else begin
            grp_first = `ADG_SEQ_GRP_C_END + 6'h01;
        end
    endfunction

    function automatic logic [5:0] grp_last(input logic [5:0] a);
        if (a < `ADG_SEQ_FIRST_CFG || a > `ADG_SEQ_LAST_CFG) begin
            grp_last = a;
        end else if (a <= `ADG_SEQ_GRP_B_END) begin
            grp_last = `ADG_SEQ_GRP_B_END;
        end else if (a <= `ADG_SEQ_GRP_C_END) begin
            grp_last = `ADG_SEQ_GRP_C_END;
        end else begin
            grp_last = `ADG_SEQ_LAST_CFG;
        end
    endfunction

    // Step choice by direction and loop setting.
    always_comb begin
        nxt_addr = addr_ff;
        if (seq_req.is_write) begin
            if (write_loop) begin
                nxt_addr = cfg_next(addr_ff);
            end
        end else begin
            case (read_mode)
                `ADG_RD_MAP: nxt_addr = map_next(addr_ff);
                `ADG_RD_TYPE: begin
                    nxt_addr = (addr_ff == `ADG_IDX_CHAN) ? addr_ff
                        : cfg_next(addr_ff);
                end
                `ADG_RD_GROUP: begin
                    nxt_addr = (addr_ff == grp_last(addr_ff))
                        ? grp_first(addr_ff) : addr_ff + 6'h01;
                end
                default: nxt_addr = addr_ff;
            endcase
        end
    end

    // Address counter, loaded at the start of a sequence.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            addr_ff <= 6'h00;
        end else if (seq_req.start) begin
            addr_ff <= seq_req.addr;
        end else if (seq_req.step) begin
            addr_ff <= nxt_addr;
        end
    end

endmodule // adg_addr_seq

// file: bench/adg_link_host.sv
// Serial host model: issues address counter commands to the block.
module adg_link_host (
    input wire logic clk,
    output adg_pkg::adg_seq_req_t seq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import adg_pkg::*;

    initial seq_req = '0;

    // One load or step command, held for a single clock.
    task automatic cmd(input logic st, input logic [5:0] a,
                       input logic w);
        @(posedge clk);
        seq_req <= '{start: st, addr: a, step: !st, is_write: w};
        @(posedge clk);
        seq_req <= '0;
    endtask
endmodule // adg_link_host

// file: bench/adg_regs_props.sv
`include "adg_params.svh"

module adg_regs_props #(
    parameter int OSR_W = 13
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire adg_pkg::adg_amm_req_t amm_req,
    input wire adg_pkg::adg_amm_rsp_t amm_rsp,
    input wire logic sample_valid,
    input wire logic [23:0] sample_data,
    input wire logic [OSR_W-1:0] oversample_ratio,
    input wire logic checksum_fail,
    input wire logic [15:0] config_checksum_value,
    input wire logic modulator_bit,
    input wire adg_pkg::adg_seq_req_t seq_req,
    input wire logic [5:0] link_addr,
    input wire adg_pkg::adg_link_cfg_t link_cfg,
    input wire logic chan_restart_ff,
    input wire logic conv_start_ff,
    input wire logic [5:0] amp_gain_factor_ff,
    input wire logic [31:0] sample_word_ff,
    input wire logic sample_ready_pin_n_o_ff,
    input wire logic sample_ready_pin_n_oe_ff,
    input wire logic bitstream_pin_o_ff,
    input wire logic bitstream_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import adg_pkg::*;
    logic bus_req;
    logic dly_wr;

    // Request present and a completed write to the delay register.
    assign bus_req = amm_req.read | amm_req.write;
    assign dly_wr = amm_req.write && !amm_rsp.waitrequest &&
        amm_req.address[7:2] == `ADG_IDX_DELAY;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    wait_first_a: assert property ($rose(bus_req) |-> amm_rsp.waitrequest)
        else $error("request start had no wait cycle");
    wait_once_a: assert property (amm_rsp.waitrequest |=>
        !amm_rsp.waitrequest) else $error("more than one wait cycle");
    idle_wait_a: assert property (!bus_req |-> !amm_rsp.waitrequest)
        else $error("waitrequest high while idle");
    restart_cause_a: assert property (
        dly_wr |=> chan_restart_ff ##1 !chan_restart_ff)
        else $error("delay write gave no single restart pulse");
    gain_legal_a: assert property (
        $onehot(amp_gain_factor_ff) && amp_gain_factor_ff <= 6'h20)
        else $error("gain factor out of range");
    crc_bits_a: assert property (
        link_cfg.crc_bits == (!link_cfg.checksum_en ? 6'h00 :
        link_cfg.crc_wide ? 6'h20 : 6'h10))
        else $error("checksum bit count wrong");
    word_bits_a: assert property (
        link_cfg.word_bits == (link_cfg.data_fmt == 2'h0 ? 6'h10 :
        link_cfg.data_fmt == 2'h1 ? 6'h18 : 6'h20))
        else $error("word bit count wrong");
    ready_low_a: assert property (sample_valid |-> ##2
        (!sample_ready_pin_n_o_ff && sample_ready_pin_n_oe_ff))
        else $error("ready pin not low after sample");
    seq_static_a: assert property (
        seq_req.step && !seq_req.start && (seq_req.is_write ?
        !link_cfg.write_loop : link_cfg.read_mode == 2'h0)
        |=> $stable(link_addr)) else $error("static address moved");

    cover property (chan_restart_ff ##[1:40] conv_start_ff);
    cover property (sample_valid && amm_req.read);
    cover property (seq_req.step && link_cfg.read_mode == 2'h3);
endmodule // adg_regs_props

bind adg_regs adg_regs_props #(.OSR_W(OSR_W)) adg_regs_props_inst (.*);

// file: bench/adg_regs_test.sv
`include "adg_params.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    fails++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module adg_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adg_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    adg_amm_req_t amm_req = '0;
    adg_amm_rsp_t amm_rsp;
    logic sample_valid = 1'b0;
    logic [23:0] sample_data = '0;
    logic checksum_fail = 1'b0;
    logic modulator_bit = 1'b0;
    adg_seq_req_t seq_req;
    adg_link_cfg_t link_cfg;
    logic [5:0] link_addr;
    logic [5:0] gain;
    logic [31:0] word;
    logic [31:0] q;
    logic restart, conv_start, pin_o, pin_oe, bs_oe, bs_o;
    int fails = 0;
    int total_checks = 0;
    int k;
    logic [5:0] wbits [4] = '{6'h10, 6'h18, 6'h20, 6'h20};
    logic [15:0] seq_tab [10] = '{16'h02CB, 16'h12CB, 16'hE41F, 16'hE7C0,
        16'hA000, 16'hA7C8, 16'h6308, 16'h638D, 16'h77C8, 16'h3008};

    // Clock and a toggling modulator bitstream.
    always #5 clk = ~clk;
    always @(posedge clk) modulator_bit <= ~modulator_bit;

    adg_regs #(.OSR_W(13)) adg_regs_inst (
        .clk(clk), .rst_b(rst_b), .amm_req(amm_req), .amm_rsp(amm_rsp),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .oversample_ratio(13'h0008), .checksum_fail(checksum_fail),
        .config_checksum_value(16'h5A3C), .modulator_bit(modulator_bit),
        .seq_req(seq_req), .link_addr(link_addr), .link_cfg(link_cfg),
        .chan_restart_ff(restart), .conv_start_ff(conv_start),
        .amp_gain_factor_ff(gain), .sample_word_ff(word),
        .sample_ready_pin_n_o_ff(pin_o), .sample_ready_pin_n_oe_ff(pin_oe),
        .bitstream_pin_o_ff(bs_o), .bitstream_pin_oe(bs_oe));

    adg_link_host adg_link_host_inst (.clk(clk), .seq_req(seq_req));

    // Holds one request until waitrequest is low at a rising edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        amm_req <= '{!w, w, a, d, 4'hF};
        do begin
            @(posedge clk);
        end while (amm_rsp.waitrequest !== 1'b0);
        q = amm_rsp.readdata;
        amm_req <= '0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex);
        bus(1'b0, a, '0);
        `CHK("readdata", ex, q)
    endtask

    // A one-cycle checksum failure, then time for the pin to follow.
    task automatic fail_pulse();
        @(posedge clk);
        checksum_fail <= 1'b1;
        @(posedge clk);
        checksum_fail <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic results();
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence of register and link scenarios.
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        chk_rd(8'h30, 32'h00A10001);
        chk_rd(8'h28, 32'h0);
        chk_rd(8'h2C, 32'h0);
        `CHK("gain", 6'h01, gain)
        `CHK("pin_oe", 1'b0, pin_oe)
        bus(1'b1, 8'h28, 32'hFFFFF003);
        for (k = 0; restart !== 1'b1 && k < 9; k++) @(negedge clk);
        `CHK("restart", 1'b1, restart)
        for (k = 0; conv_start !== 1'b1 && k < 40; k++) @(negedge clk);
        `CHK("delay", 8, k)
        chk_rd(8'h28, 32'h00000003);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h2C, 32'hFFFFFFF8 | i);
            chk_rd(8'h2C, i);
            `CHK("gain", i < 6 ? 6'h01 << i : 6'h01, gain)
        end
        bus(1'b1, 8'h30, 32'hFFFFCFFF);
        chk_rd(8'h30, 32'h00F7C801);
        @(negedge clk);
        `CHK("pin", 2'b11, {pin_o, pin_oe})
        `CHK("bs_oe", 1'b1, bs_oe)
        `CHK("bs_o", ~modulator_bit, bs_o)
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 8'h30, 32'h00208000 | f << 16 | f[0] << 18);
            repeat (2) @(negedge clk);
            `CHK("word_bits", wbits[f], link_cfg.word_bits)
            `CHK("crc_bits", f[0] ? 6'h20 : 6'h10, link_cfg.crc_bits)
            `CHK("checksum_en", 1'b1, link_cfg.checksum_en)
            `CHK("bs_oe", 1'b0, bs_oe)
            `CHK("bs_o", 1'b0, bs_o)
            `CHK("pin_oe", 1'b0, pin_oe)
        end
        @(posedge clk);
        sample_data <= 24'h812345;
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("word", 32'hFF812345, word)
        `CHK("pin", 2'b01, {pin_o, pin_oe})
        fork
            chk_rd(8'h00, 32'h00812345);
            begin
                repeat (2) @(posedge clk);
                sample_data <= 24'h000777;
                sample_valid <= 1'b1;
                @(posedge clk);
                sample_valid <= 1'b0;
            end
        join
        chk_rd(8'h00, 32'h00000777);
        bus(1'b1, 8'h30, 32'h00278001);
        chk_rd(8'h30, 32'h00278000);
        chk_rd(8'h30, 32'h00278001);
        bus(1'b1, 8'h30, 32'h00004000);
        fail_pulse();
        `CHK("pin", 2'b01, {pin_o, pin_oe})
        bus(1'b1, 8'h7C, 32'h00A50000);
        repeat (2) @(negedge clk);
        `CHK("pin_oe", 1'b0, pin_oe)
        bus(1'b1, 8'h30, 32'h0);
        fail_pulse();
        `CHK("pin_oe", 1'b0, pin_oe)
        chk_rd(8'h7C, 32'h00A55A3C);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 8'h30, {8'h00, seq_tab[i][15:13], 21'h0});
            adg_link_host_inst.cmd(1'b1, seq_tab[i][11:6], seq_tab[i][12]);
            adg_link_host_inst.cmd(1'b0, 6'h00, seq_tab[i][12]);
            @(negedge clk);
            `CHK("link_addr", seq_tab[i][5:0], link_addr)
        end
        results();
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        results();
    end
endmodule // adg_regs_test
